// ### dv/lane_tx_model.sv
// behavioural lane transmitter: junk words, one start-of-data word, numbered data
`timescale 1ns/1ps
module lane_tx_model #(
   parameter int LANES = 4,
   parameter int JUNK = 2,
   parameter int WORDS = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench control
   input wire logic start,
   input wire logic stall,
   input wire logic [LANES-1:0][3:0] skew,
   // lane side
   output lat_align_pkg::lane_word_t [LANES-1:0] lane_word,
   output logic [LANES-1:0] lane_valid,
   input wire logic [LANES-1:0] lane_ready
);
   logic [LANES-1:0] acc;
   logic go;
   logic hold;
   logic held;
   logic offer;
   int idx [LANES];
   int wt [LANES];

   // ---------------------------------------------------------------
   // handshake taken at the rising edge, acted on at the falling edge
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      acc <= lane_valid & lane_ready;
      go <= start;
      hold <= stall;
   end

   always @(negedge clk or posedge rst) begin
      for (int i = 0; i < LANES; i++) begin
         if (rst) begin
            idx[i] = JUNK + WORDS;
            wt[i] = 0;
            lane_valid[i] = 1'b0;
            lane_word[i] = '0;
         end else begin
            held = lane_valid[i] && !acc[i];
            offer = 1'b0;
            if (lane_valid[i] && acc[i]) idx[i]++;
            if (go) begin
               wt[i] = skew[i];
               idx[i] = 0;
               held = 1'b0;
            end else if (!held && wt[i] > 0) wt[i]--;
            else if (!held && idx[i] < JUNK + WORDS && !hold) offer = 1'b1;
            lane_valid[i] = held || offer;
            // idle lanes toggle so stale data never looks valid
            if (offer) lane_word[i] = {idx[i] == JUNK, 8'(i), 24'(idx[i] - JUNK)};
            else if (!held) lane_word[i] = ~lane_word[i];
         end
      end
   end
endmodule // lane_tx_model

// ### dv/test_rx_multiframe_latency_align.sv
// self-checking bench for the receive multiframe latency aligner
`timescale 1ns/1ps
module test_rx_multiframe_latency_align;
   localparam int LANES = 4;
   localparam int WORDS = 12;
   logic CLK_SYS, RESET, REG_WR, REG_RD, REG_RVALID, SYNC_EVENT, OUT_VALID, OUT_READY;
   logic LINK_ALIGNED, LOCAL_MF_BOUNDARY, tx_start, tx_stall, synced, lat_done, la_q, exp_bnd;
   logic full_seen = 1'b0;
   logic [11:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, sh_off, sh_d;
   logic [3:0] CFG_OCTETS_PER_FRAME;
   lat_align_pkg::lane_word_t [LANES-1:0] LANE_WORD;
   logic [LANES-1:0] LANE_VALID, LANE_READY, sof_seen;
   logic [LANES*lat_align_pkg::LANE_W-1:0] OUT_DATA;
   logic [LANES-1:0][3:0] skew;
   logic [15:0] bh;
   int errors = 0;
   int check_count = 0;
   int ec = 0;
   int cpm = 8;
   int act_off, act_d, n_out, exp_lat;

   rx_multiframe_latency_align #(.NUM_LANES(LANES)) uut (.CLK_SYS(CLK_SYS), .RESET(RESET),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .CFG_OCTETS_PER_FRAME(CFG_OCTETS_PER_FRAME), .SYNC_EVENT(SYNC_EVENT),
      .LANE_WORD(LANE_WORD), .LANE_VALID(LANE_VALID), .LANE_READY(LANE_READY),
      .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
      .LINK_ALIGNED(LINK_ALIGNED), .LOCAL_MF_BOUNDARY(LOCAL_MF_BOUNDARY));

   lane_tx_model #(.LANES(LANES), .WORDS(WORDS)) tx (.clk(CLK_SYS), .rst(RESET),
      .start(tx_start), .stall(tx_stall), .skew(skew), .lane_word(LANE_WORD),
      .lane_valid(LANE_VALID), .lane_ready(LANE_READY));

   initial begin
      CLK_SYS = 1'b0;
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   function automatic logic [LANES*32-1:0] exp_word(input int n);
      for (int i = 0; i < LANES; i++) exp_word[i*32 +: 32] = {8'(i), 24'(n)};
   endfunction

   // ---------------------------------------------------------------
   // monitor: boundary phase, release moment, output order, latency
   // ---------------------------------------------------------------
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         synced = 1'b0;
         la_q = 1'b0;
         bh = '0;
      end else begin
         exp_bnd = synced && (ec - 1) % cpm == act_off;
         if (!synced || ec >= 1) chk(LOCAL_MF_BOUNDARY === exp_bnd, "boundary");
         bh = {bh[14:0], LOCAL_MF_BOUNDARY};
         if (LINK_ALIGNED === 1'b1 && !la_q) begin
            chk(bh[act_d] === 1'b1, "release not delay cycles after boundary");
            chk(sof_seen === '1, "release before all lanes arrived");
         end
         la_q = (LINK_ALIGNED === 1'b1);
         if (LANE_VALID[0] && LANE_READY[0] && LANE_WORD[0].sof && !lat_done) begin
            exp_lat = ec % cpm;
            lat_done = 1'b1;
         end
         for (int i = 0; i < LANES; i++) begin
            if (LANE_VALID[i] && LANE_READY[i] && LANE_WORD[i].sof) sof_seen[i] = 1'b1;
         end
         if (LANE_READY !== '1) full_seen = 1'b1;
         if (OUT_VALID === 1'b1 && OUT_READY) begin
            chk(OUT_DATA === exp_word(n_out), "output word");
            n_out++;
         end
         if (SYNC_EVENT) begin
            ec = 0;
            synced = 1'b1;
            cpm = 32 * int'(CFG_OCTETS_PER_FRAME) / 4;
            act_off = sh_off;
            act_d = (sh_d > 8'h0c) ? 12 : int'(sh_d);
            lat_done = 1'b0;
            sof_seen = '0;
            n_out = 0;
         end else ec++;
      end
   end

   // ---------------------------------------------------------------
   // register port and link runs
   // ---------------------------------------------------------------
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge CLK_SYS);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge CLK_SYS);
      REG_WR = 1'b0;
      if (a == lat_align_pkg::ADDR_MULTIFRAME_OFFSET) sh_off = d;
      if (a == lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY) sh_d = d;
   endtask

   task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge CLK_SYS);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge CLK_SYS);
      REG_RD = 1'b0;
      chk(REG_RVALID === 1'b1 && REG_RDATA === e, "register read");
   endtask

   task automatic run(input logic [3:0] f, input logic [7:0] off, input logic [7:0] d);
      int k;
      logic [7:0] noff;
      reg_wr(lat_align_pkg::ADDR_MULTIFRAME_OFFSET, off);
      reg_wr(lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY, d);
      @(negedge CLK_SYS);
      SYNC_EVENT = 1'b1;
      // mode changes only together with a sync, so the phase never wraps early
      CFG_OCTETS_PER_FRAME = f;
      for (int i = 0; i < LANES; i++) skew[i] = 4'($urandom_range(15));
      @(negedge CLK_SYS);
      SYNC_EVENT = 1'b0;
      tx_start = 1'b1;
      @(negedge CLK_SYS);
      tx_start = 1'b0;
      k = 0;
      while (n_out < WORDS && k < 600) begin
         @(negedge CLK_SYS);
         OUT_READY = ($urandom_range(3) != 0);
         tx_stall = ($urandom_range(3) == 0);
         k++;
      end
      chk(n_out == WORDS, "link never delivered all words");
      // new offset must wait for the next sync
      noff = 8'((int'(off) + 1) % (8 * int'(f)));
      reg_wr(lat_align_pkg::ADDR_MULTIFRAME_OFFSET, noff);
      repeat (20) @(negedge CLK_SYS);
      reg_rd(lat_align_pkg::ADDR_MEASURED_LATENCY, 8'(exp_lat));
      chk(REG_RDATA < 8'(8 * int'(f)), "latency reading not modulo multiframe");
      reg_wr(lat_align_pkg::ADDR_MEASURED_LATENCY, ~8'(exp_lat));
      reg_rd(lat_align_pkg::ADDR_MEASURED_LATENCY, 8'(exp_lat));
      reg_rd(lat_align_pkg::ADDR_MULTIFRAME_OFFSET, noff);
      reg_rd(lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY, d);
      reg_rd(12'h300, lat_align_pkg::RDATA_UNMAPPED);
   endtask

   initial begin
      int f, o, d;
      void'($urandom(32'h0ee24239));
      RESET = 1'b1;
      REG_ADDR = '0;
      REG_WDATA = '0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      SYNC_EVENT = 1'b0;
      OUT_READY = 1'b1;
      CFG_OCTETS_PER_FRAME = 4'h1;
      tx_start = 1'b0;
      tx_stall = 1'b0;
      skew = '0;
      sh_off = '0;
      sh_d = '0;
      repeat (2) @(negedge CLK_SYS);
      RESET = 1'b0;
      reg_rd(lat_align_pkg::ADDR_MEASURED_LATENCY, lat_align_pkg::MEASURED_LATENCY_RST);
      reg_rd(lat_align_pkg::ADDR_MULTIFRAME_OFFSET, lat_align_pkg::MULTIFRAME_OFFSET_RST);
      reg_rd(lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY,
         lat_align_pkg::BUFFER_RELEASE_DELAY_RST);
      run(4'h2, 8'h00, 8'h0c);
      run(4'h2, 8'h09, 8'h06);
      run(4'h1, 8'h07, 8'h00);
      run(4'h1, 8'h00, 8'h08);
      run(4'h2, 8'h03, 8'hff);
      run(4'h1, 8'h02, 8'h03);
      for (int r = 0; r < 3; r++) begin
         f = $urandom_range(1, 2);
         o = $urandom_range(8 * f - 1);
         d = $urandom_range(8 * f < 12 ? 8 * f : 12);
         run(4'(f), 8'(o), 8'(d));
      end
      chk(full_seen === 1'b1, "lane back pressure never seen");
      stop_test;
   end

   // nine runs of a few hundred cycles at most, with ample margin
   initial begin
      #1000000;
      errors++;
      stop_test;
   end
endmodule // test_rx_multiframe_latency_align

// ### hw/lat_align_pkg.sv
// shared constants, types and helpers for the multiframe latency aligner
package lat_align_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int REG_AW = 12;
   localparam int REG_DW = 8;
   localparam logic [11:0] ADDR_MEASURED_LATENCY = 12'h302;
   localparam logic [11:0] ADDR_MULTIFRAME_OFFSET = 12'h304;
   localparam logic [11:0] ADDR_BUFFER_RELEASE_DELAY = 12'h306;
   localparam logic [7:0] MULTIFRAME_OFFSET_RST = 8'h00;
   localparam logic [7:0] BUFFER_RELEASE_DELAY_RST = 8'h00;
   localparam logic [7:0] MEASURED_LATENCY_RST = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // -----------------------------------------------------------------
   // timing and size figures: release delay in parallel-clock cycles
   // -----------------------------------------------------------------
   localparam logic [7:0] RELEASE_DELAY_MAX = 8'h0c;
   localparam int FRAMES_PER_MF = 32;
   localparam int BYTES_PER_PCLK = 4;
   localparam int LANE_W = 32;
   localparam int FIFO_DEPTH = 4;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic sof;
      logic [LANE_W-1:0] data;
   } lane_word_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ALIGN = 4'b0010,
      ST_HOLD  = 4'b0100,
      ST_RUN   = 4'b1000
   } align_state_t;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // 32 frames of F octets over 4 octets per parallel clock
   function automatic logic [7:0] cycles_per_mf(input logic [3:0] f);
      cycles_per_mf = 8'((FRAMES_PER_MF * int'(f)) / BYTES_PER_PCLK);
   endfunction

   // (a - b) modulo m, both operands already below m
   function automatic logic [7:0] wrap_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] m);
      wrap_sub = (a >= b) ? 8'(a - b) : 8'(a + m - b);
   endfunction

endpackage

// ### hw/lmfc_gen.sv
// aligned multiframe phase counter and offset local multiframe clock
`timescale 1ns/1ps
module lmfc_gen (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic sync,
   input wire logic [7:0] cpm,
   input wire logic [7:0] offset,
   // phase outputs
   output logic [7:0] phase,
   output logic [7:0] local_phase,
   output logic local_bnd,
   output logic aligned
);
   logic [7:0] phase_r, phase_nxt;
   logic aligned_r, aligned_nxt;
   logic [7:0] last;

   assign last = (cpm == 8'h00) ? 8'h00 : 8'(cpm - 8'h01);

   // phase counts parallel clocks, so offsets are in that unit
   always_comb begin
      aligned_nxt = aligned_r || sync;
      if (sync) begin
         phase_nxt = 8'h00;
      end else if (phase_r >= last) begin
         phase_nxt = 8'h00;
      end else begin
         phase_nxt = 8'(phase_r + 8'h01);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_r <= 8'h00;
         aligned_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         aligned_r <= aligned_nxt;
      end
   end

   assign phase = phase_r;
   assign aligned = aligned_r;
   assign local_phase = lat_align_pkg::wrap_sub(phase_r, offset, cpm);
   assign local_bnd = aligned_r && (local_phase == 8'h00);

endmodule // lmfc_gen

// ### hw/rx_multiframe_latency_align.sv
// receive multiframe alignment, release delay and latency readback
//
// Operation
// - Each link keeps a local multiframe clock delayed from the aligned one by an offset.
// - All lanes of a link are read together inside one local multiframe.
// - Samples are held until release-delay cycles after the local boundary.
// - Release delay covers 0 to 12 parallel-clock cycles.
// - Offset and release delay are counted in parallel-clock cycles.
// - Parallel clock is a quarter of the lane byte rate.
// - A multiframe is 8 cycles for F of 1, 16 for F of 2.
// - Read-only latency: aligned phase at lane 0's first start-of-data sample after alignment.
// - Offset sits at 0x304, release delay at 0x306, both writable.
// - A sync event aligns the internal multiframe phase to zero.
// - A multiframe holds 32 frames, giving 8 times F parallel cycles.
`timescale 1ns/1ps
module rx_multiframe_latency_align #(
   parameter int NUM_LANES = 4,
   parameter int FIFO_DEPTH = lat_align_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // register port
   input wire logic [11:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   // link configuration
   input wire logic [3:0] CFG_OCTETS_PER_FRAME,
   input wire logic SYNC_EVENT,
   // lane inputs
   input wire lat_align_pkg::lane_word_t [NUM_LANES-1:0] LANE_WORD,
   input wire logic [NUM_LANES-1:0] LANE_VALID,
   output logic [NUM_LANES-1:0] LANE_READY,
   // aligned output
   output logic [NUM_LANES*lat_align_pkg::LANE_W-1:0] OUT_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   // status
   output logic LINK_ALIGNED,
   output logic LOCAL_MF_BOUNDARY
);
   localparam int LW = lat_align_pkg::LANE_W;
   localparam int WW = $bits(lat_align_pkg::lane_word_t);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   lat_align_pkg::align_state_t st_r, st_nxt;
   logic [7:0] mf_offset_r, mf_offset_nxt, rel_delay_r, rel_delay_nxt;
   logic [7:0] act_offset_r, act_offset_nxt, act_delay_r, act_delay_nxt;
   logic [7:0] latency_r, latency_nxt, cnt_r, cnt_nxt;
   logic lat_done_r, lat_done_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [NUM_LANES*LW-1:0] out_data_r, out_data_nxt;
   logic out_valid_r, out_valid_nxt, aligned_r, aligned_nxt, bnd_r;
   logic [NUM_LANES-1:0] fifo_ready, head_valid, pop;
   lat_align_pkg::lane_word_t head [NUM_LANES];
   logic [7:0] cpm, phase, local_phase;
   logic local_bnd, mf_aligned, all_valid, all_sof, lat_hit;

   // ---------------------------------------------------------------
   // per-lane buffers and the one shared multiframe clock
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      logic [WW-1:0] head_bits;
      sample_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
         .clk(CLK_SYS),
         .rst(RESET),
         .in_valid(LANE_VALID[i]),
         .in_ready(fifo_ready[i]),
         .in_data(LANE_WORD[i]),
         .out_valid(head_valid[i]),
         .out_ready(pop[i]),
         .out_data(head_bits)
      );
      assign head[i] = head_bits;
   end

   assign cpm = lat_align_pkg::cycles_per_mf(CFG_OCTETS_PER_FRAME);

   lmfc_gen u_lmfc (
      .clk(CLK_SYS),
      .rst(RESET),
      .sync(SYNC_EVENT),
      .cpm(cpm),
      .offset(act_offset_r),
      .phase(phase),
      .local_phase(local_phase),
      .local_bnd(local_bnd),
      .aligned(mf_aligned)
   );

   always_comb begin
      all_valid = 1'b1;
      all_sof = 1'b1;
      for (int i = 0; i < NUM_LANES; i++) begin
         all_valid = all_valid && head_valid[i];
         all_sof = all_sof && head_valid[i] && head[i].sof;
      end
   end

   // first post-alignment start-of-data sample of lane 0 entering its buffer
   assign lat_hit = LANE_VALID[0] && fifo_ready[0] && LANE_WORD[0].sof && !lat_done_r;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   always_comb begin
      mf_offset_nxt = mf_offset_r;
      rel_delay_nxt = rel_delay_r;
      act_offset_nxt = act_offset_r;
      act_delay_nxt = act_delay_r;
      latency_nxt = latency_r;
      lat_done_nxt = lat_done_r;
      rvalid_nxt = REG_RD;
      rdata_nxt = rdata_r;
      if (REG_WR && REG_ADDR == lat_align_pkg::ADDR_MULTIFRAME_OFFSET) begin
         mf_offset_nxt = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY) begin
         rel_delay_nxt = REG_WDATA;
      end
      if (REG_RD) begin
         case (REG_ADDR)
            lat_align_pkg::ADDR_MEASURED_LATENCY: rdata_nxt = latency_r;
            lat_align_pkg::ADDR_MULTIFRAME_OFFSET: rdata_nxt = mf_offset_r;
            lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY: rdata_nxt = rel_delay_r;
            default: rdata_nxt = lat_align_pkg::RDATA_UNMAPPED;
         endcase
      end
      if (lat_hit && mf_aligned) begin
         latency_nxt = phase;
         lat_done_nxt = 1'b1;
      end
      if (SYNC_EVENT) begin
         // new settings only land here, never mid-multiframe
         act_offset_nxt = mf_offset_r;
         act_delay_nxt = (rel_delay_r > lat_align_pkg::RELEASE_DELAY_MAX) ?
                         lat_align_pkg::RELEASE_DELAY_MAX : rel_delay_r;
         lat_done_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         mf_offset_r <= lat_align_pkg::MULTIFRAME_OFFSET_RST;
         rel_delay_r <= lat_align_pkg::BUFFER_RELEASE_DELAY_RST;
         act_offset_r <= lat_align_pkg::MULTIFRAME_OFFSET_RST;
         act_delay_r <= lat_align_pkg::BUFFER_RELEASE_DELAY_RST;
         latency_r <= lat_align_pkg::MEASURED_LATENCY_RST;
         lat_done_r <= 1'b0;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         mf_offset_r <= mf_offset_nxt;
         rel_delay_r <= rel_delay_nxt;
         act_offset_r <= act_offset_nxt;
         act_delay_r <= act_delay_nxt;
         latency_r <= latency_nxt;
         lat_done_r <= lat_done_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ---------------------------------------------------------------
   // alignment and release
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      pop = '0;
      out_data_nxt = out_data_r;
      out_valid_nxt = out_valid_r && !OUT_READY;
      if (st_r == lat_align_pkg::ST_ALIGN || st_r == lat_align_pkg::ST_HOLD) begin
         // drop stale words ahead of the first data sample
         for (int i = 0; i < NUM_LANES; i++) begin
            pop[i] = head_valid[i] && !head[i].sof;
         end
      end
      case (st_r)
         lat_align_pkg::ST_IDLE: begin
            st_nxt = lat_align_pkg::ST_IDLE;
         end
         lat_align_pkg::ST_ALIGN: begin
            if (local_bnd) begin
               if (act_delay_r == 8'h00) begin
                  st_nxt = all_sof ? lat_align_pkg::ST_RUN : lat_align_pkg::ST_ALIGN;
               end else begin
                  st_nxt = lat_align_pkg::ST_HOLD;
                  cnt_nxt = 8'h01;
               end
            end
         end
         lat_align_pkg::ST_HOLD: begin
            if (cnt_r >= act_delay_r) begin
               // late lane: retry at the next local boundary
               st_nxt = all_sof ? lat_align_pkg::ST_RUN : lat_align_pkg::ST_ALIGN;
            end else begin
               cnt_nxt = 8'(cnt_r + 8'h01);
            end
         end
         lat_align_pkg::ST_RUN: begin
            if (all_valid && (!out_valid_r || OUT_READY)) begin
               pop = '1;
               out_valid_nxt = 1'b1;
               for (int i = 0; i < NUM_LANES; i++) begin
                  out_data_nxt[i*LW +: LW] = head[i].data;
               end
            end
         end
         default: begin
            st_nxt = lat_align_pkg::ST_IDLE;
         end
      endcase
      if (SYNC_EVENT) begin
         st_nxt = lat_align_pkg::ST_ALIGN;
         out_valid_nxt = 1'b0;
      end
      aligned_nxt = (st_nxt == lat_align_pkg::ST_RUN);
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st_r <= lat_align_pkg::ST_IDLE;
         cnt_r <= 8'h00;
         out_data_r <= '0;
         out_valid_r <= 1'b0;
         aligned_r <= 1'b0;
         bnd_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         out_data_r <= out_data_nxt;
         out_valid_r <= out_valid_nxt;
         aligned_r <= aligned_nxt;
         bnd_r <= local_bnd;
      end
   end

   assign REG_RDATA = rdata_r;
   assign REG_RVALID = rvalid_r;
   assign LANE_READY = fifo_ready;
   assign OUT_DATA = out_data_r;
   assign OUT_VALID = out_valid_r;
   assign LINK_ALIGNED = aligned_r;
   assign LOCAL_MF_BOUNDARY = bnd_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   AST_OFFSET_WRITE: assert property (
      REG_WR && REG_ADDR == lat_align_pkg::ADDR_MULTIFRAME_OFFSET
      |=> mf_offset_r == $past(REG_WDATA))
      else $error("offset write not stored");
   AST_READ_ANSWER: assert property (
      REG_RD && REG_ADDR == lat_align_pkg::ADDR_BUFFER_RELEASE_DELAY
      && !REG_WR |=> REG_RVALID && REG_RDATA == rel_delay_r)
      else $error("release delay readback wrong");
   AST_APPLY_AT_SYNC: assert property (
      !SYNC_EVENT |=> $stable(act_offset_r) && $stable(act_delay_r))
      else $error("settings changed without sync");
   AST_DELAY_RANGE: assert property (
      act_delay_r <= lat_align_pkg::RELEASE_DELAY_MAX)
      else $error("active release delay above 12");
   AST_MF_LENGTH: assert property (
      (CFG_OCTETS_PER_FRAME == 4'h1 |-> cpm == 8'h08)
      and (CFG_OCTETS_PER_FRAME == 4'h2 |-> cpm == 8'h10))
      else $error("multiframe length wrong");
   AST_LOCAL_OFFSET: assert property (
      local_bnd && act_offset_r < cpm |-> phase == act_offset_r)
      else $error("local boundary not at offset");
   AST_SYNC_PHASE: assert property (
      SYNC_EVENT |=> phase == 8'h00)
      else $error("sync did not realign phase");
   AST_RELEASE_TIME: assert property (
      st_r == lat_align_pkg::ST_ALIGN && local_bnd && !SYNC_EVENT
      && act_delay_r == 8'h03 |=> (st_r == lat_align_pkg::ST_HOLD)[*3]
      ##1 st_r != lat_align_pkg::ST_HOLD)
      else $error("release not three cycles after boundary");
   AST_LANES_TOGETHER: assert property (
      st_r == lat_align_pkg::ST_RUN && pop != '0 |-> pop == '1)
      else $error("lanes read apart");
   AST_LATENCY_CAPTURE: assert property (
      lat_hit && mf_aligned && !SYNC_EVENT
      |=> latency_r == $past(phase) && latency_r < cpm)
      else $error("latency not captured");

   COV_RUN: cover property (st_r == lat_align_pkg::ST_ALIGN ##[1:200]
      st_r == lat_align_pkg::ST_RUN);
   COV_LATENCY: cover property (lat_hit && mf_aligned);
   COV_HOLD_MAX: cover property (st_r == lat_align_pkg::ST_HOLD
      && cnt_r == lat_align_pkg::RELEASE_DELAY_MAX);
   COV_RETRY: cover property (st_r == lat_align_pkg::ST_HOLD
      ##1 st_r == lat_align_pkg::ST_ALIGN);

endmodule // rx_multiframe_latency_align

// ### hw/sample_fifo.sv
// small synchronous fifo holding one lane's words until release
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic ready_r, ready_nxt;
   logic push, pop;

   assign push = in_valid && ready_r;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign in_ready = ready_r;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : PW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
         count_nxt = CW'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = CW'(count_r - 1'b1);
      end
      ready_nxt = (count_nxt != CNT_FULL);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b1;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         ready_r <= ready_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

endmodule // sample_fifo
